// *** osf_pkg.sv ***
// Purpose: shared constants for the optical sample buffer
// Assumes: register indices as printed, byte address is index times four
// Notes:   all widths and depths fixed
package osf_pkg;
  // ********************************************************************
  // register map (indices; byte address = index * 4)
  // ********************************************************************
  localparam logic [7:0]  IDX_STATUS    = 8'h00;
  localparam logic [7:0]  IDX_MASK      = 8'h02;
  localparam logic [7:0]  IDX_WPTR      = 8'h04;
  localparam logic [7:0]  IDX_OVF       = 8'h05;
  localparam logic [7:0]  IDX_RPTR      = 8'h06;
  localparam logic [7:0]  IDX_DATA      = 8'h07;
  localparam logic [7:0]  IDX_CFG       = 8'h08;
  localparam int          ADDR_W        = 12;
  // ********************************************************************
  // field layout and reset values
  // ********************************************************************
  localparam int          CFG_AVG_LSB   = 5;
  localparam int          CFG_WRAP_BIT  = 4;
  localparam int          CFG_AF_LSB    = 0;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam int          STAT_AFULL    = 7;
  localparam int          STAT_NEW      = 6;
  localparam logic [7:0]  STAT_USED     = 8'hC0;
  // ********************************************************************
  // buffer geometry
  // ********************************************************************
  localparam int          DEPTH         = 32;
  localparam int          PTR_W         = 5;
  localparam int          CNT_W         = 6;
  localparam int          CHAN_W        = 18;
  localparam int          NCHAN         = 3;
  localparam int          SAMPLE_W      = 54;
  localparam int          ACC_W         = 23;
  localparam logic [2:0]  AVG_MAX_SHIFT = 3'h5;
  localparam logic [4:0]  OVF_MAX       = 5'h1F;
  localparam logic [1:0]  PART_LAST     = 2'h2;
endpackage

// *** osf_mem.sv ***
// Purpose: sample storage, one write port and a registered read port
// Assumes: read-first when both ports hit the same slot
// Notes:   contents are not zeroed by reset
`timescale 1ns/10ps
module osf_mem (
  input  wire logic                         clk,
  input  wire logic                         we,
  input  wire logic [osf_pkg::PTR_W-1:0]    waddr,
  input  wire logic [osf_pkg::SAMPLE_W-1:0] wdata,
  input  wire logic [osf_pkg::PTR_W-1:0]    raddr,
  output logic      [osf_pkg::SAMPLE_W-1:0] rdata
);
  logic [osf_pkg::SAMPLE_W-1:0] mem_q [osf_pkg::DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule

// *** osf_top.sv ***
// Purpose: sample buffer with averaging, pointers, lost-sample count, apb access
// Assumes: channel samples and proximity mode come from logic on pclk
// Notes:   zero-wait apb slave; data register hands out one byte per read
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module osf_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [osf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       chan_valid,
  input  wire logic [osf_pkg::CHAN_W-1:0] chan_data0,
  input  wire logic [osf_pkg::CHAN_W-1:0] chan_data1,
  input  wire logic [osf_pkg::CHAN_W-1:0] chan_data2,
  input  wire logic [1:0]                 num_chan,
  input  wire logic                       prox_mode,
  output logic                            irq
);
  // ********************************************************************
  // declarations
  // ********************************************************************
  logic [7:0]                      cfg_q, cfg_d, mask_q, mask_d, status_q, status_d;
  logic [osf_pkg::PTR_W-1:0]       wptr_q, wptr_d, rptr_q, rptr_d, ovf_q, ovf_d;
  logic [osf_pkg::PTR_W-1:0]       mem_waddr;
  logic                            full_q, full_d, prox_q, af_lvl_q, af_now;
  logic [1:0]                      chan_idx_q, chan_idx_d, part_q, part_d, last_chan;
  logic [4:0]                      avg_cnt_q, avg_cnt_d, avg_last;
  logic [2:0]                      avg_shift;
  logic [31:0]                     prdata_q, prdata_d;
  logic                            setup_ph, rd_acc, wr_acc, addr_ok, mapped;
  logic                            hit_stat, hit_mask, hit_wptr, hit_ovf, hit_rptr;
  logic                            hit_data, hit_cfg, host_ptr_wr, prox_chg;
  logic                            empty, pop_done, push_req, mem_we;
  logic [osf_pkg::CNT_W-1:0]       count_q;
  logic [osf_pkg::SAMPLE_W-1:0]    mem_rdata, push_data;
  logic [osf_pkg::CHAN_W-1:0]      chan_in [osf_pkg::NCHAN];
  logic [osf_pkg::CHAN_W-1:0]      cur_chan;
  logic [7:0]                      data_byte, stat_set, stat_clr;

  // ********************************************************************
  // apb decode
  // ********************************************************************
  assign setup_ph = psel & ~penable;
  assign rd_acc   = psel & penable & ~pwrite;
  assign wr_acc   = psel & penable & pwrite;
  assign addr_ok  = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);

  always_comb
  begin
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    hit_wptr = 1'b0;
    hit_ovf  = 1'b0;
    hit_rptr = 1'b0;
    hit_data = 1'b0;
    hit_cfg  = 1'b0;
    if (!addr_ok)
      hit_stat = 1'b0;
    else if (paddr[9:2] == osf_pkg::IDX_STATUS)
      hit_stat = 1'b1;
    else if (paddr[9:2] == osf_pkg::IDX_MASK)
      hit_mask = 1'b1;
    else if (paddr[9:2] == osf_pkg::IDX_WPTR)
      hit_wptr = 1'b1;
    else if (paddr[9:2] == osf_pkg::IDX_OVF)
      hit_ovf = 1'b1;
    else if (paddr[9:2] == osf_pkg::IDX_RPTR)
      hit_rptr = 1'b1;
    else if (paddr[9:2] == osf_pkg::IDX_DATA)
      hit_data = 1'b1;
    else if (paddr[9:2] == osf_pkg::IDX_CFG)
      hit_cfg = 1'b1;
  end

  assign mapped      = hit_stat | hit_mask | hit_wptr | hit_ovf | hit_rptr | hit_data | hit_cfg;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~mapped;
  assign prdata      = prdata_q;
  assign host_ptr_wr = wr_acc & (hit_wptr | hit_rptr | hit_ovf);
  assign prox_chg    = prox_mode ^ prox_q;

  // ********************************************************************
  // averaging front end
  // ********************************************************************
  assign avg_shift = (cfg_q[7:5] > osf_pkg::AVG_MAX_SHIFT) ? osf_pkg::AVG_MAX_SHIFT
                                                           : cfg_q[7:5];
  assign avg_last  = 5'((6'h01 << avg_shift) - 6'h01);
  assign chan_in[0] = chan_data0;
  assign chan_in[1] = chan_data1;
  assign chan_in[2] = chan_data2;
  // a shrinking field can leave the count above the new end, hence >=
  assign push_req  = chan_valid & (avg_cnt_q >= avg_last) & ~prox_chg;

  always_comb
  begin
    avg_cnt_d = avg_cnt_q;
    if (prox_chg)
      avg_cnt_d = 5'h00;
    else if (chan_valid)
      avg_cnt_d = (avg_cnt_q >= avg_last) ? 5'h00 : 5'(avg_cnt_q + 5'h01);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      avg_cnt_q <= 5'h00;
    else
      avg_cnt_q <= avg_cnt_d;
  end

  for (genvar c = 0; c < osf_pkg::NCHAN; c++)
  begin : g_acc
    logic [osf_pkg::ACC_W-1:0] acc_q, acc_d, acc_sh;
    always_comb
    begin
      acc_d = acc_q;
      if (prox_chg)
        acc_d = '0;
      else if (chan_valid)
        acc_d = ((avg_cnt_q == 5'h00) ? '0 : acc_q) + {5'h00, chan_in[c]};
    end
    assign acc_sh = acc_d >> avg_shift;
    assign push_data[c*osf_pkg::CHAN_W +: osf_pkg::CHAN_W] = acc_sh[osf_pkg::CHAN_W-1:0];
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        acc_q <= '0;
      else
        acc_q <= acc_d;
    end
  end

  // ********************************************************************
  // pointers, lost-sample count and byte walk
  // ********************************************************************
  assign empty     = ~full_q & (wptr_q == rptr_q);
  assign count_q   = full_q ? 6'(osf_pkg::DEPTH) : {1'b0, 5'(wptr_q - rptr_q)};
  assign last_chan = (num_chan == 2'h0) ? 2'h0 : 2'(num_chan - 2'h1);
  assign pop_done  = rd_acc & hit_data & ~empty & (part_q == osf_pkg::PART_LAST)
                   & (chan_idx_q >= last_chan);

  always_comb
  begin
    wptr_d     = wptr_q;
    rptr_d     = rptr_q;
    ovf_d      = ovf_q;
    full_d     = full_q;
    chan_idx_d = chan_idx_q;
    part_d     = part_q;
    mem_we     = 1'b0;
    if (wr_acc && hit_wptr)
    begin
      wptr_d = pwdata[4:0];
      full_d = 1'b0;
    end
    if (wr_acc && hit_ovf)
      ovf_d = pwdata[4:0];
    if (wr_acc && hit_rptr)
    begin
      rptr_d     = pwdata[4:0];
      full_d     = 1'b0;
      chan_idx_d = 2'h0;
      part_d     = 2'h0;
    end
    // one byte per read, address untouched by the slave
    if (rd_acc && hit_data && !empty && !(wr_acc && hit_rptr))
    begin
      if (part_q != osf_pkg::PART_LAST)
        part_d = 2'(part_q + 2'h1);
      else if (chan_idx_q < last_chan)
      begin
        part_d     = 2'h0;
        chan_idx_d = 2'(chan_idx_q + 2'h1);
      end
      else
      begin
        part_d     = 2'h0;
        chan_idx_d = 2'h0;
        rptr_d     = 5'(rptr_q + 5'h01);
        ovf_d      = 5'h00;
        full_d     = 1'b0;
      end
    end
    mem_waddr = wptr_d;
    if (push_req)
    begin
      if (!full_d)
      begin
        mem_we = 1'b1;
        wptr_d = 5'(wptr_d + 5'h01);
        full_d = (wptr_d == rptr_d);
      end
      else if (cfg_q[osf_pkg::CFG_WRAP_BIT])
      begin
        // overwrite oldest; read side is pushed along with it
        mem_we     = 1'b1;
        wptr_d     = 5'(wptr_d + 5'h01);
        rptr_d     = wptr_d;
        chan_idx_d = 2'h0;
        part_d     = 2'h0;
        ovf_d      = (ovf_d == osf_pkg::OVF_MAX) ? ovf_d : 5'(ovf_d + 5'h01);
      end
      else
      begin
        // dropped: nothing stored until room is made
        ovf_d = (ovf_d == osf_pkg::OVF_MAX) ? ovf_d : 5'(ovf_d + 5'h01);
      end
    end
    if (prox_chg)
    begin
      wptr_d     = 5'h00;
      rptr_d     = 5'h00;
      ovf_d      = 5'h00;
      full_d     = 1'b0;
      chan_idx_d = 2'h0;
      part_d     = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_q     <= 5'h00;
      rptr_q     <= 5'h00;
      ovf_q      <= 5'h00;
      full_q     <= 1'b0;
      chan_idx_q <= 2'h0;
      part_q     <= 2'h0;
      prox_q     <= 1'b0;
    end
    else
    begin
      wptr_q     <= wptr_d;
      rptr_q     <= rptr_d;
      ovf_q      <= ovf_d;
      full_q     <= full_d;
      chan_idx_q <= chan_idx_d;
      part_q     <= part_d;
      prox_q     <= prox_mode;
    end
  end

  // read address follows the next pointer so data is ready right after a move
  osf_mem u_mem (
    .clk   (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (push_data),
    .raddr (rptr_d),
    .rdata (mem_rdata)
  );

  // ********************************************************************
  // registers, status and read data
  // ********************************************************************
  assign cur_chan  = mem_rdata[chan_idx_q*osf_pkg::CHAN_W +: osf_pkg::CHAN_W];
  assign data_byte = (part_q == 2'h0) ? {6'h00, cur_chan[17:16]} :
                     (part_q == 2'h1) ? cur_chan[15:8] : cur_chan[7:0];
  assign af_now    = count_q >= {2'h0, cfg_q[3:0]};
  assign stat_set  = {(af_now & ~af_lvl_q), mem_we, 6'h00};
  // clear only what the reader actually saw, so a late event survives
  assign stat_clr  = (rd_acc && hit_stat) ? prdata_q[7:0] : 8'h00;
  assign irq       = |(status_q & mask_q);

  always_comb
  begin
    cfg_d    = cfg_q;
    mask_d   = mask_q;
    status_d = ((status_q & ~stat_clr) | stat_set) & osf_pkg::STAT_USED;
    prdata_d = prdata_q;
    if (wr_acc && hit_cfg)
      cfg_d = pwdata[7:0];
    if (wr_acc && hit_mask)
      mask_d = pwdata[7:0] & osf_pkg::STAT_USED;
    if (setup_ph)
    begin
      prdata_d = 32'h0000_0000;
      if (hit_stat)
        prdata_d[7:0] = status_q;
      else if (hit_mask)
        prdata_d[7:0] = mask_q;
      else if (hit_wptr)
        prdata_d[4:0] = wptr_q;
      else if (hit_ovf)
        prdata_d[4:0] = ovf_q;
      else if (hit_rptr)
        prdata_d[4:0] = rptr_q;
      else if (hit_data)
        prdata_d[7:0] = empty ? 8'h00 : data_byte;
      else if (hit_cfg)
        prdata_d[7:0] = cfg_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q    <= osf_pkg::CFG_RESET;
      mask_q   <= osf_pkg::MASK_RESET;
      status_q <= osf_pkg::STATUS_RESET;
      prdata_q <= 32'h0000_0000;
      // high at reset: a zero threshold must not flag the empty buffer as a new event
      af_lvl_q <= 1'b1;
    end
    else
    begin
      cfg_q    <= cfg_d;
      mask_q   <= mask_d;
      status_q <= status_d;
      prdata_q <= prdata_d;
      af_lvl_q <= af_now;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wptr_step: assert property ((push_req & ~full_q & ~host_ptr_wr & ~pop_done)
    |=> wptr_q == 5'($past(wptr_q) + 5'h01)) else $error("write pointer did not step");
  a_rptr_step: assert property ((pop_done & ~host_ptr_wr & ~prox_chg & ~(push_req & full_q))
    |=> rptr_q == 5'($past(rptr_q) + 5'h01)) else $error("read pointer did not step");
  a_ovf_count: assert property ((push_req & full_q & ~pop_done & ~host_ptr_wr
    & (ovf_q != osf_pkg::OVF_MAX)) |=> ovf_q == 5'($past(ovf_q) + 5'h01))
    else $error("lost count did not step");
  a_ovf_clear: assert property ((pop_done & ~host_ptr_wr & ~prox_chg) |=> ovf_q == 5'h00)
    else $error("lost count not cleared after sample read");
  a_afull_flag: assert property ((af_now & ~af_lvl_q) |=> status_q[osf_pkg::STAT_AFULL])
    else $error("almost-full flag not set");
  a_full_hold: assert property ((full_q & ~cfg_q[osf_pkg::CFG_WRAP_BIT] & push_req
    & ~pop_done & ~host_ptr_wr) |-> ~mem_we ##1 (full_q && $stable(wptr_q)))
    else $error("sample stored into full buffer");
  a_wrap_write: assert property ((full_q & cfg_q[osf_pkg::CFG_WRAP_BIT] & push_req
    & ~pop_done & ~host_ptr_wr) |-> mem_we ##1 (full_q && wptr_q == rptr_q))
    else $error("wrap did not overwrite");
  a_prox_clear: assert property (prox_chg |=> (count_q == 6'h00) && (ovf_q == 5'h00)
    && (part_q == 2'h0))
    else $error("buffer not emptied on proximity change");
  a_avg_long: assert property ((cfg_q[7:5] >= 3'h5) |-> avg_last == 5'h1F)
    else $error("long averaging code not 32");
  a_reread_back: assert property ((wr_acc & hit_rptr & ~prox_chg & ~push_req)
    |=> rptr_q == $past(pwdata[4:0]) && part_q == 2'h0)
    else $error("read pointer rewrite lost");

  c_wrap: cover property (full_q & cfg_q[osf_pkg::CFG_WRAP_BIT] & push_req);
  c_pop: cover property (pop_done);
  c_afull: cover property (irq & status_q[osf_pkg::STAT_AFULL]);
  c_reread: cover property (wr_acc & hit_rptr ##[1:20] pop_done);
endmodule

// *** osf_host_model.sv ***
// Purpose: host processor model, an apb master that reads and writes the buffer registers
// Assumes: one pclk domain; the slave may stretch the access with pready low
// Notes:   hung rises when a transfer waits past its bound
`timescale 1ns/10ps
module osf_host_model (
  input  wire logic                       pclk,
  output logic                            psel,
  output logic                            penable,
  output logic                            pwrite,
  output logic      [osf_pkg::ADDR_W-1:0] paddr,
  output logic      [31:0]                pwdata,
  input  wire logic [31:0]                prdata,
  input  wire logic                       pready,
  input  wire logic                       pslverr,
  output logic                            hung
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    hung    = 1'b0;
  end

  // ******************************************************************
  // one transfer: setup, access held until pready, then release
  // ******************************************************************
  // the bench writes cfg and mask, restarts pointers and lost count, and steps the read pointer back
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
      hung = 1'b1;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released data lines must not look like a held value
    pwdata  <= ~wd;
  endtask
endmodule

// *** tb_optical_sample_fifo.sv ***
// Purpose: self-checking bench for the optical sample buffer
// Assumes: zero-wait apb slave, samples pushed by single chan_valid pulses
// Notes:   expected values come from the register layout, not from the design
`timescale 1ns/10ps
module tb_optical_sample_fifo;
  localparam logic [11:0] A_STAT = 12'h000;
  localparam logic [11:0] A_MASK = 12'h008;
  localparam logic [11:0] A_WPTR = 12'h010;
  localparam logic [11:0] A_OVF  = 12'h014;
  localparam logic [11:0] A_RPTR = 12'h018;
  localparam logic [11:0] A_DATA = 12'h01C;
  localparam logic [11:0] A_CFG  = 12'h020;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        chan_valid, prox_mode, irq, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] chan_data0, chan_data1, chan_data2;
  logic [1:0]  num_chan;
  int          miscompares, check_count;

  osf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_valid(chan_valid), .chan_data0(chan_data0),
    .chan_data1(chan_data1), .chan_data2(chan_data2), .num_chan(num_chan),
    .prox_mode(prox_mode), .irq(irq));

  osf_host_model HOST (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hung(hung));

  // ******************************************************************
  // shared tasks
  // ******************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic e);
    HOST.xfer(1'b0, a, 32'h0000_0000, d, e);
    if (hung)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    HOST.xfer(1'b1, a, v, d, e);
    if (hung)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    rd(a, d, e);
    check(what, exp, d);
  endtask

  task automatic push(input logic [17:0] v);
    @(posedge pclk);
    chan_valid <= 1'b1;
    chan_data0 <= v;
    chan_data1 <= v + 18'h0_0001;
    chan_data2 <= v + 18'h0_0002;
    @(posedge pclk);
    chan_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // channel c of a sample holds v0 + c, read high byte first
  task automatic rd_sample(input logic [17:0] v0, input int nch);
    logic [17:0] v;
    logic [31:0] exp;
    for (int c = 0; c < nch; c++)
    begin
      v = v0 + 18'(c);
      for (int b = 0; b < 3; b++)
      begin
        exp = (b == 0) ? {30'h0000_0000, v[17:16]} :
              (b == 1) ? {24'h00_0000, v[15:8]} : {24'h00_0000, v[7:0]};
        rdchk("data byte", A_DATA, exp);
      end
    end
  endtask

  task automatic restart();
    wr(A_WPTR, 32'h0000_0000);
    wr(A_RPTR, 32'h0000_0000);
    wr(A_OVF, 32'h0000_0000);
  endtask

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_reset();
    logic [31:0] d;
    logic        e;
    rdchk("cfg reset", A_CFG, 32'h0000_0000);
    rdchk("wptr reset", A_WPTR, 32'h0000_0000);
    rdchk("rptr reset", A_RPTR, 32'h0000_0000);
    rdchk("ovf reset", A_OVF, 32'h0000_0000);
    rdchk("status reset", A_STAT, 32'h0000_0000);
    rdchk("mask reset", A_MASK, 32'h0000_0000);
    rd(12'h3FC, d, e);
    check("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
    $display("test reset done");
  endtask

  task automatic t_stream();
    push(18'h3_1234);
    rdchk("wptr after push", A_WPTR, 32'h0000_0001);
    rd_sample(18'h3_1234, 3);
    rdchk("rptr after sample", A_RPTR, 32'h0000_0001);
    check("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    wr(A_RPTR, 32'h0000_0000);
    rd_sample(18'h3_1234, 3);
    rdchk("rptr after reread", A_RPTR, 32'h0000_0001);
    num_chan <= 2'h2;
    push(18'h0_2468);
    rd_sample(18'h0_2468, 2);
    rdchk("rptr after two channels", A_RPTR, 32'h0000_0002);
    $display("test stream and reread done");
  endtask

  task automatic t_full(input logic wrap);
    num_chan <= 2'h1;
    wr(A_CFG, {27'h000_0000, wrap, 4'h0});
    restart();
    for (int i = 0; i < 34; i++)
      push(18'h0_0100 + 18'(i));
    rdchk("ovf when full", A_OVF, 32'h0000_0002);
    rdchk("wptr when full", A_WPTR, {30'h0000_0000, wrap, 1'b0});
    rd_sample(wrap ? 18'h0_0102 : 18'h0_0100, 1);
    rdchk("ovf after read", A_OVF, 32'h0000_0000);
    $display("test full wrap=%0d done", wrap);
  endtask

  task automatic t_avg();
    int n;
    for (int code = 0; code < 8; code++)
    begin
      n = 1 << ((code > 4) ? 5 : code);
      wr(A_CFG, 32'(code) << 5);
      restart();
      for (int k = 0; k < n - 1; k++)
        push(18'(2 * k));
      rdchk("wptr before last", A_WPTR, 32'h0000_0000);
      push(18'(2 * (n - 1)));
      rdchk("wptr after last", A_WPTR, 32'h0000_0001);
      rd_sample(18'(n - 1), 1);
    end
    $display("test averaging done");
  endtask

  task automatic t_afull();
    logic [31:0] d;
    logic        e;
    wr(A_CFG, 32'h0000_0003);
    wr(A_MASK, 32'h0000_0080);
    restart();
    rd(A_STAT, d, e);
    push(18'h0_0011);
    push(18'h0_0022);
    check("irq below", 32'h0000_0000, {31'h0000_0000, irq});
    push(18'h0_0033);
    check("irq at level", 32'h0000_0001, {31'h0000_0000, irq});
    rdchk("status afull", A_STAT, 32'h0000_00C0);
    @(posedge pclk);
    check("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    $display("test almost full done");
  endtask

  task automatic t_prox();
    push(18'h0_0044);
    prox_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk("wptr enter", A_WPTR, 32'h0000_0000);
    rdchk("rptr enter", A_RPTR, 32'h0000_0000);
    rdchk("empty data", A_DATA, 32'h0000_0000);
    push(18'h0_0055);
    prox_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    rdchk("wptr exit", A_WPTR, 32'h0000_0000);
    $display("test proximity done");
  endtask

  // ******************************************************************
  // clock, reset and main sequence
  // ******************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    finish_test();
  end

  initial
  begin
    miscompares = 0;
    check_count = 0;
    presetn     = 1'b0;
    chan_valid  = 1'b0;
    chan_data0  = 18'h0_0000;
    chan_data1  = 18'h0_0000;
    chan_data2  = 18'h0_0000;
    num_chan    = 2'h3;
    prox_mode   = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stream();
    t_full(1'b0);
    t_full(1'b1);
    t_avg();
    t_afull();
    t_prox();
    finish_test();
  end
endmodule
